// file: rtl/flash_protect_security_status.sv
// Flash ready/busy, block protection status and security control
`include "flash_protect_params.svh"

// Overview of operation
// - Ready flag low while busy, high after
// - Failed operation keeps ready flag low
// - Hardware reset returns ready flag to one
// - Status bits 21:16 show block protection
// - Small part: bits 21:20 read zero
// - Security bit0 writable, power-on resets to one
// - Protection commands only in three modes
// - Protection write sets one block only
// - Erase clears blocks 0-3 or 4-5
// - Secure erase wipes every protection bit
// - Security active needs enable and all protected
// - Enable changed only after key, within window
module flash_protect_security_status (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic op_start_i,
    input wire logic op_done_i,
    input wire logic op_fail_i,
    input flash_protect_pkg::boot_mode_t boot_mode_i,
    input wire logic small_part_i,
    input flash_protect_pkg::prot_bits_t prot_init_i,
    input wire logic prot_write_i,
    input wire logic [2:0] prot_block_i,
    input wire logic prot_erase_i,
    input wire logic prot_group_i,
    output logic ready_busy_o,
    output flash_protect_pkg::prot_bits_t block_protect_o,
    output logic secure_active_o,
    output logic irq_o
);
    import flash_protect_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Declarations

    // Bus slave
    logic ack_ff;          // Registered acknowledge
    logic [31:0] dat_ff;   // Registered read data
    logic [31:0] nxt_dat;  // Read mux output
    logic req;             // Request present
    logic take;            // Edge at which the master sees ack
    logic wr_take;         // Write takes effect here
    logic rd_take;         // Read completes here
    logic hit_sec;         // Address decodes
    logic hit_stat;
    logic hit_irq_stat;
    logic hit_irq_mask;

    // Automatic operation tracking
    op_state_t op_state_ff;
    op_state_t nxt_op_state;
    logic ready;

    // Protection command gating
    logic mode_ok;
    logic wr_ok;
    logic erase_ok;
    prot_bits_t valid_mask;

    // Interrupts
    event_t status_ff;     // Sticky event bits
    event_t mask_ff;       // Enable per event
    event_t ev;            // Events this cycle
    event_t clr;           // Bits reported by the read being completed
    logic irq_ff;

    // Bundle shared with the key keeper
    key_wr_if kif ();

    ////////////////////////////////////////////////////////////////////
    // Wishbone slave: ack one cycle after the request shows up
    // Every address is answered, mapped or not, so a stray access
    // cannot hang the master; holes read zero.

    assign req = wb_cyc_i && wb_stb_i;
    assign take = req && ack_ff;
    assign wr_take = take && wb_we_i;
    assign rd_take = take && !wb_we_i;

    // Full compare: no alias can reach the key keeper
    assign hit_sec = (wb_adr_i == `SEC_CTRL_ADDR);
    assign hit_stat = (wb_adr_i == `FLASH_STAT_ADDR);
    assign hit_irq_stat = (wb_adr_i == `IRQ_STAT_ADDR);
    assign hit_irq_mask = (wb_adr_i == `IRQ_MASK_ADDR);

    // Ack drops the cycle after it is given, even if the master lingers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'h0;
        end else begin
            ack_ff <= req && !ack_ff;
        end
    end

    // Read mux; unmapped addresses and reserved bits read zero
    always_comb begin
        nxt_dat = `WORD_ZERO;
        if (hit_sec) begin
            nxt_dat[`SEC_BIT] = kif.sec_en;
        end else if (hit_stat) begin
            nxt_dat[`PROT_MSB:`PROT_LSB] = block_protect_o;
            nxt_dat[`RDY_BIT] = ready;
        end else if (hit_irq_stat) begin
            nxt_dat[`EV_W-1:0] = status_ff;
        end else if (hit_irq_mask) begin
            nxt_dat[`EV_W-1:0] = mask_ff;
        end
    end

    // Read data captured as ack rises and held until the next read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_ff <= `WORD_ZERO;
        end else if (req && !ack_ff && !wb_we_i) begin
            dat_ff <= nxt_dat;
        end
    end

    // Bus outputs come straight from flops
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;

    ////////////////////////////////////////////////////////////////////
    // Security key keeper; every write to its address reaches it, only full-word writes count

    // Byte-lane writes still pass; the keeper ignores them
    assign kif.wr_stb = wr_take && hit_sec;
    assign kif.wr_full = (wb_sel_i == `FULL_SEL);
    assign kif.wr_data = wb_dat_i;

    sec_key_unlock i_sec_key_unlock (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .por_i(por_i),
        .kif(kif.keeper)
    );

    ////////////////////////////////////////////////////////////////////
    // Automatic operation: the sequencer reports start, done and fail.
    // No check of misuse while busy; the sequencer owner must wait.
    // A failure is sticky on purpose: the array is no longer trusted,
    // so software must reset before the next command.

    always_comb begin
        nxt_op_state = op_state_ff;
        unique case (op_state_ff)
            OP_READY: begin
                if (op_start_i) begin
                    nxt_op_state = OP_BUSY;
                end
            end
            OP_BUSY: begin
                if (op_fail_i) begin
                    nxt_op_state = OP_FAILED;
                end else if (op_done_i) begin
                    nxt_op_state = OP_READY;
                end
            end
            OP_FAILED: begin
                // Stuck until hardware reset
                nxt_op_state = OP_FAILED;
            end
            default: begin
                nxt_op_state = OP_READY;
            end
        endcase
    end

    // Hardware reset is the only way out of a failure
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            op_state_ff <= OP_READY;
        end else begin
            op_state_ff <= nxt_op_state;
        end
    end

    // Ready is decoded from the state, never stored twice
    assign ready = (op_state_ff == OP_READY);
    assign ready_busy_o = ready;

    ////////////////////////////////////////////////////////////////////
    // Protection commands from the sequencer; the bus cannot reach them
    // Commands are one-cycle pulses; a held pulse repeats the action

    assign mode_ok = (boot_mode_i != MODE_OTHER);
    // Secure part refuses writes; an erase then wipes all blocks
    assign wr_ok = prot_write_i && mode_ok && !secure_active_o;
    assign erase_ok = prot_erase_i && mode_ok;

    // Image flops keep their value across hardware reset
    prot_bit_store i_prot_bit_store (
        .clk_i(clk_i),
        .por_i(por_i),
        .init_i(prot_init_i),
        .write_i(wr_ok),
        .block_i(prot_block_i),
        .erase_i(erase_ok),
        .group_i(prot_group_i),
        .erase_all_i(secure_active_o),
        .small_part_i(small_part_i),
        .bits_o(block_protect_o)
    );

    // Missing blocks of the small part count as protected here
    assign valid_mask = small_part_i ? `SMALL_MASK : `FULL_MASK;
    assign secure_active_o = kif.sec_en && (&(block_protect_o | ~valid_mask));

    ////////////////////////////////////////////////////////////////////
    // Interrupts: sticky events, cleared by reading the status word
    // Bit 0 done, 1 fail, 2 protection command, 3 unused unlock

    always_comb begin
        ev = '0;
        ev[`EV_DONE] = (op_state_ff == OP_BUSY) && op_done_i && !op_fail_i;
        ev[`EV_FAIL] = (op_state_ff == OP_BUSY) && op_fail_i;
        ev[`EV_PROT] = wr_ok || erase_ok;
        ev[`EV_KEY] = kif.key_expired;
    end

    // Clear only what the read returned, so a late event is not lost
    assign clr = (rd_take && hit_irq_stat) ? dat_ff[`EV_W-1:0] : '0;

    // Reads of other registers leave the bits alone
    // Set wins over clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_ff <= '0;
        end else begin
            status_ff <= (status_ff & ~clr) | ev;
        end
    end

    // Mask lives in byte lane 0; writes to the status word are dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_ff <= '0;
        end else if (wr_take && hit_irq_mask && wb_sel_i[0]) begin
            mask_ff <= wb_dat_i[`EV_W-1:0];
        end
    end

    // Registered level; lags the status bit by one clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_ff <= 1'h0;
        end else begin
            irq_ff <= |(status_ff & mask_ff);
        end
    end

    // Level output; the core's controller samples it as a level
    assign irq_o = irq_ff;

    ////////////////////////////////////////////////////////////////////
    // Checks
    // All run on the one clock; hardware reset switches them off except the ready check after reset,
    // and those on protection bits, small_zero_a aside, also wait out power-on reset, since the
    // stored image is unknown until it is loaded.

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Ready/busy flag
    rdy_after_reset_a: assert property (disable iff (1'h0)
        rst_i |=> ready_busy_o)
        else $error("ready flag not one after reset");

    busy_on_start_a: assert property ((ready && op_start_i) |=> !ready_busy_o)
        else $error("ready flag not cleared at start");

    ready_on_done_a: assert property (((op_state_ff == OP_BUSY) && op_done_i && !op_fail_i)
        |=> ready_busy_o)
        else $error("ready flag not set at completion");

    fail_holds_busy_a: assert property (((op_state_ff == OP_BUSY) && op_fail_i)
        |=> (!ready_busy_o)[*4])
        else $error("ready flag recovered after failure");

    // Register reads
    stat_read_a: assert property ((req && !ack_ff && !wb_we_i && hit_stat)
        |=> (wb_dat_o[`PROT_MSB:`PROT_LSB] == $past(block_protect_o))
            && (wb_dat_o[`RDY_BIT] == $past(ready)))
        else $error("status read does not match state");

    // Protection bits
    small_zero_a: assert property (small_part_i |-> block_protect_o[5:4] == 2'h0)
        else $error("missing block bits read nonzero");

    one_block_a: assert property (disable iff (rst_i || por_i)
        wr_ok |=> $countones(block_protect_o ^ $past(block_protect_o)) <= 1)
        else $error("protection write touched several blocks");

    group_erase_a: assert property (disable iff (rst_i || por_i)
        (erase_ok && !secure_active_o && !wr_ok && !prot_group_i && !small_part_i)
        |=> (block_protect_o[3:0] == 4'h0)
            && (block_protect_o[5:4] == $past(block_protect_o[5:4])))
        else $error("group erase hit wrong blocks");

    secure_erase_a: assert property (disable iff (rst_i || por_i)
        (erase_ok && secure_active_o) |=> block_protect_o == 6'h00)
        else $error("secure erase left protection bits");

    mode_refuse_a: assert property (disable iff (rst_i || por_i)
        (prot_write_i && !prot_erase_i && (boot_mode_i == MODE_OTHER))
        |=> $stable(block_protect_o))
        else $error("protection write taken in other mode");

    // Ignored writes and bus timing
    stat_write_ign_a: assert property ((wr_take && hit_stat && !op_start_i
        && !op_done_i && !op_fail_i) |=> $stable(ready_busy_o))
        else $error("status write had an effect");

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held for two cycles");

    // Interrupt line follows the masked sticky bits one clock later
    irq_level_a: assert property (irq_o == $past(|(status_ff & mask_ff)))
        else $error("interrupt level does not follow status");

    // Main scenarios
    fail_path_c: cover property ((op_state_ff == OP_BUSY) && op_fail_i);
    secure_erase_c: cover property (erase_ok && secure_active_o);
    irq_raise_c: cover property ($rose(irq_o));
    stat_clear_c: cover property (rd_take && hit_irq_stat && (status_ff != '0));
endmodule // flash_protect_security_status

// file: shared/flash_protect_params.svh
// Register addresses, field positions, reset values and timing counts
`ifndef FLASH_PROTECT_PARAMS_SVH
`define FLASH_PROTECT_PARAMS_SVH

// Register byte addresses
`define SEC_CTRL_ADDR 32'h4004_0500
`define FLASH_STAT_ADDR 32'h4004_0520
`define IRQ_STAT_ADDR 32'h4004_0540
`define IRQ_MASK_ADDR 32'h4004_0544

// Field positions
`define RDY_BIT 0
`define PROT_LSB 16
`define PROT_MSB 21
`define SEC_BIT 0

// Reset values
`define SEC_RST 1'h1
`define WORD_ZERO 32'h0000_0000

// Protection layout
`define NUM_BLOCKS 6
`define GROUP0_LAST 3
`define SMALL_MASK 6'h0F
`define FULL_MASK 6'h3F

// Unlock key and window length in clocks
`define UNLOCK_KEY 32'hA74A_9D23
`define UNLOCK_CLKS 5'h10
`define FULL_SEL 4'hF

// Interrupt event bits
`define EV_DONE 0
`define EV_FAIL 1
`define EV_PROT 2
`define EV_KEY 3
`define EV_W 4

`endif

// file: shared/flash_protect_pkg.sv
// Types shared by the flash protection and status logic
`include "flash_protect_params.svh"

package flash_protect_pkg;

    // Boot strap modes seen by the protection logic
    typedef enum logic [1:0] {
        MODE_SINGLE_CHIP,
        MODE_SINGLE_BOOT,
        MODE_WRITER,
        MODE_OTHER
    } boot_mode_t;

    // Automatic operation tracking
    typedef enum logic [1:0] {
        OP_READY,
        OP_BUSY,
        OP_FAILED
    } op_state_t;

    typedef logic [`NUM_BLOCKS-1:0] prot_bits_t;
    typedef logic [`EV_W-1:0] event_t;

endpackage

// file: shared/key_wr_if.sv
// Bus-side write path into the security key keeper
interface key_wr_if;
    logic wr_stb;         // One-cycle pulse: write taken at security address
    logic wr_full;        // Write used all four byte lanes
    logic [31:0] wr_data; // Write data
    logic sec_en;         // Security enable bit
    logic window_open;    // Unlock window running
    logic key_expired;    // Pulse: window ran out unused

    modport bus (output wr_stb, output wr_full, output wr_data,
                 input sec_en, input window_open, input key_expired);
    modport keeper (input wr_stb, input wr_full, input wr_data,
                    output sec_en, output window_open, output key_expired);
endinterface

// file: rtl/sec_key_unlock.sv
// Security enable bit guarded by a key write and a short unlock window
`include "flash_protect_params.svh"

module sec_key_unlock (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    key_wr_if.keeper kif
);
    import flash_protect_pkg::*;

    logic [4:0] window_ff; // Clocks left in the unlock window
    logic sec_ff;          // Security enable, kept across hardware reset
    logic expired_ff;      // Window expiry pulse
    logic is_key;
    logic open_w;
    logic accept;

    assign is_key = kif.wr_full && (kif.wr_data == `UNLOCK_KEY);
    assign open_w = (window_ff != 5'h00);
    // Only a full-word write inside the window may change the bit
    assign accept = kif.wr_stb && kif.wr_full && open_w;

    ////////////////////////////////////////////////////////////////////
    // Unlock window: loaded by the key, closed by use or by timeout
    always_ff @(posedge clk_i) begin
        if (rst_i || por_i) begin
            window_ff <= 5'h00;
        end else if (accept) begin
            window_ff <= 5'h00;
        end else if (kif.wr_stb && is_key && !open_w) begin
            window_ff <= `UNLOCK_CLKS;
        end else if (open_w) begin
            window_ff <= window_ff - 5'h01;
        end
    end

    // Only power-on reset touches this bit; reserved bits are not stored
    always_ff @(posedge clk_i) begin
        if (por_i) begin
            sec_ff <= `SEC_RST;
        end else if (accept) begin
            sec_ff <= kif.wr_data[`SEC_BIT];
        end
    end

    // Expiry pulse so software learns a key went unused
    always_ff @(posedge clk_i) begin
        if (rst_i || por_i) begin
            expired_ff <= 1'h0;
        end else begin
            expired_ff <= (window_ff == 5'h01) && !accept;
        end
    end

    assign kif.sec_en = sec_ff;
    assign kif.window_open = open_w;
    assign kif.key_expired = expired_ff;

    ////////////////////////////////////////////////////////////////////
    sec_por_value_a: assert property (@(posedge clk_i) por_i |=> sec_ff)
        else $error("security enable not set by power-on reset");
    sec_change_guard_a: assert property (@(posedge clk_i) disable iff (por_i)
        (!$past(por_i) && $changed(sec_ff)) |-> $past(accept))
        else $error("security enable changed without unlock");
    key_window_len_a: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
        (kif.wr_stb && is_key && !open_w) |=> window_ff == `UNLOCK_CLKS)
        else $error("unlock window not loaded with its length");
    unlock_seen_c: cover property (@(posedge clk_i) disable iff (rst_i || por_i)
        accept);
endmodule // sec_key_unlock

// file: rtl/prot_bit_store.sv
// Nonvolatile image of the per-block protection bits
`include "flash_protect_params.svh"

module prot_bit_store (
    input wire logic clk_i,
    input wire logic por_i,
    input flash_protect_pkg::prot_bits_t init_i,
    input wire logic write_i,
    input wire logic [2:0] block_i,
    input wire logic erase_i,
    input wire logic group_i,
    input wire logic erase_all_i,
    input wire logic small_part_i,
    output flash_protect_pkg::prot_bits_t bits_o
);
    import flash_protect_pkg::*;

    prot_bits_t bit_ff; // Stored bits, survive hardware reset

    ////////////////////////////////////////////////////////////////////
    // One flop per block; write wins over erase in the same cycle
    for (genvar i = 0; i < `NUM_BLOCKS; i++) begin : g_blk
        always_ff @(posedge clk_i) begin
            if (por_i) begin
                bit_ff[i] <= init_i[i];
            end else if (write_i && (block_i == 3'(i))) begin
                bit_ff[i] <= 1'h1;
            end else if (erase_i && (erase_all_i || (group_i == (i > `GROUP0_LAST)))) begin
                bit_ff[i] <= 1'h0;
            end
        end
    end

    // Small part has no blocks 4 and 5; their bits read as zero
    assign bits_o = small_part_i ? (bit_ff & `SMALL_MASK) : bit_ff;
endmodule // prot_bit_store

// file: testbench/flash_protect_security_status_bench.sv
// Self-checking bench for the flash status, protection and security block
`include "flash_protect_params.svh"

module flash_protect_security_status_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import flash_protect_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Stimulus and observed signals
    logic clk_i, rst_i, por_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
    logic [3:0] wb_sel_i;
    logic op_start_i, op_done_i, op_fail_i, small_part_i;
    boot_mode_t boot_mode_i;
    prot_bits_t prot_init_i, block_protect_o;
    logic prot_write_i, prot_erase_i, prot_group_i;
    logic [2:0] prot_block_i;
    logic ready_busy_o, secure_active_o, irq_o;
    int errors;
    int num_checks;
    prot_bits_t exp_prot; // Running expectation of the protection bits

    // Device under test
    flash_protect_security_status i_flash_protect_security_status (
        .clk_i, .rst_i, .por_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
        .wb_sel_i, .wb_dat_o, .wb_ack_o, .op_start_i, .op_done_i, .op_fail_i,
        .boot_mode_i, .small_part_i, .prot_init_i, .prot_write_i, .prot_block_i,
        .prot_erase_i, .prot_group_i, .ready_busy_o, .block_protect_o,
        .secure_active_o, .irq_o
    );

    // 25 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Closing report, the only place the run ends
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Single comparison kind: a 32-bit value, case equality so X never matches
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Wait edges, then let that edge's updates land before sampling
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // Classic cycle: hold the request until ack is sampled high, bounded wait
    task automatic wb_xfer(input logic we, input logic [31:0] adr, input logic [31:0] dat,
                           input logic [3:0] sel, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++) @(posedge clk_i);
        if (n == 20) begin
            errors++;
            $display("MISMATCH bus ack expected 1 seen 0");
            wrap_up();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        // Idle cycle so the slave can drop ack before the next request
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [31:0] adr, input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] q;
        wb_xfer(1'b1, adr, dat, sel, q);
    endtask

    task automatic rd_chk(input string what, input logic [31:0] adr, input logic [31:0] exp);
        logic [31:0] q;
        wb_xfer(1'b0, adr, 32'h0000_0000, 4'hF, q);
        chk(what, exp, q);
    endtask

    // One-cycle sequencer pulse: 0 start, 1 done, 2 fail
    task automatic op_pulse(input int k);
        @(posedge clk_i);
        op_start_i <= (k == 0);
        op_done_i <= (k == 1);
        op_fail_i <= (k == 2);
        @(posedge clk_i);
        op_start_i <= 1'b0;
        op_done_i <= 1'b0;
        op_fail_i <= 1'b0;
        step(1);
    endtask

    // One-cycle protection command: write of a block or erase of a group
    task automatic prot_cmd(input logic wr_n_er, input logic [2:0] blk, input logic grp,
                            input boot_mode_t m);
        @(posedge clk_i);
        boot_mode_i <= m;
        prot_block_i <= blk;
        prot_group_i <= grp;
        prot_write_i <= wr_n_er;
        prot_erase_i <= !wr_n_er;
        @(posedge clk_i);
        prot_write_i <= 1'b0;
        prot_erase_i <= 1'b0;
        step(1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values, ignored writes, unmapped space, small variant
    task automatic t_reset;
        rd_chk("status", `FLASH_STAT_ADDR, 32'h0021_0001);
        rd_chk("security", `SEC_CTRL_ADDR, 32'h0000_0001);
        rd_chk("irq status", `IRQ_STAT_ADDR, 32'h0000_0000);
        rd_chk("irq mask", `IRQ_MASK_ADDR, 32'h0000_0000);
        wr(`FLASH_STAT_ADDR, 32'hFFFF_FFFF, 4'hF);
        rd_chk("status", `FLASH_STAT_ADDR, 32'h0021_0001);
        wr(`SEC_CTRL_ADDR, 32'h0000_0000, 4'hF);
        rd_chk("security", `SEC_CTRL_ADDR, 32'h0000_0001);
        rd_chk("unmapped", 32'h4004_0504, 32'h0000_0000);
        @(posedge clk_i);
        small_part_i <= 1'b1;
        rd_chk("status", `FLASH_STAT_ADDR, 32'h0001_0001);
        chk("protect", 32'h01, 32'(block_protect_o));
        @(posedge clk_i);
        small_part_i <= 1'b0;
        $display("test reset done");
    endtask

    // Block writes in each mode, group erases, secure erase, key unlock
    task automatic t_protect;
        prot_cmd(1'b0, 3'd0, 1'b0, MODE_SINGLE_CHIP);
        chk("protect", 32'h20, 32'(block_protect_o));
        prot_cmd(1'b0, 3'd0, 1'b1, MODE_SINGLE_CHIP);
        chk("protect", 32'h00, 32'(block_protect_o));
        prot_cmd(1'b1, 3'd2, 1'b0, MODE_OTHER);
        chk("protect", 32'h00, 32'(block_protect_o));
        exp_prot = '0;
        // Each permitted mode in turn, one block per command
        for (int b = 0; b < 6; b++) begin
            prot_cmd(1'b1, 3'(b), 1'b0, boot_mode_t'(b % 3));
            exp_prot[b] = 1'b1;
            chk("protect", 32'(exp_prot), 32'(block_protect_o));
        end
        chk("secure", 32'h1, 32'(secure_active_o));
        prot_cmd(1'b0, 3'd0, 1'b1, MODE_OTHER);
        chk("protect", 32'h3F, 32'(block_protect_o));
        prot_cmd(1'b0, 3'd0, 1'b0, MODE_SINGLE_CHIP);
        chk("protect", 32'h00, 32'(block_protect_o));
        for (int b = 0; b < 6; b++) prot_cmd(1'b1, 3'(b), 1'b0, MODE_SINGLE_BOOT);
        rd_chk("status", `FLASH_STAT_ADDR, 32'h003F_0001);
        // Key, then a partial write that must not count, then the real data
        wr(`SEC_CTRL_ADDR, `UNLOCK_KEY, 4'hF);
        wr(`SEC_CTRL_ADDR, 32'h0000_0000, 4'h3);
        wr(`SEC_CTRL_ADDR, 32'hFFFF_FFFE, 4'hF);
        rd_chk("security", `SEC_CTRL_ADDR, 32'h0000_0000);
        chk("secure", 32'h0, 32'(secure_active_o));
        prot_cmd(1'b0, 3'd0, 1'b0, MODE_WRITER);
        chk("protect", 32'h30, 32'(block_protect_o));
        prot_cmd(1'b0, 3'd0, 1'b1, MODE_WRITER);
        chk("protect", 32'h00, 32'(block_protect_o));
        rd_chk("irq status", `IRQ_STAT_ADDR, 32'h0000_0004);
        $display("test protect done");
    endtask

    // Failed operation holds busy until a hardware reset
    task automatic t_fail;
        op_pulse(0);
        chk("ready", 32'h0, 32'(ready_busy_o));
        op_pulse(2);
        op_pulse(1);
        step(10);
        chk("ready", 32'h0, 32'(ready_busy_o));
        rd_chk("irq status", `IRQ_STAT_ADDR, 32'h0000_0002);
        // Recovery reset of 13 clocks, over half a microsecond
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (13) @(posedge clk_i);
        rst_i <= 1'b0;
        step(1);
        chk("ready", 32'h1, 32'(ready_busy_o));
        rd_chk("security", `SEC_CTRL_ADDR, 32'h0000_0000);
        $display("test fail done");
    endtask

    // Done and key-expiry events through status, mask and the interrupt line
    task automatic t_irq;
        wr(`IRQ_MASK_ADDR, 32'h0000_0001, 4'h1);
        rd_chk("irq mask", `IRQ_MASK_ADDR, 32'h0000_0001);
        op_pulse(0);
        rd_chk("status", `FLASH_STAT_ADDR, 32'h0000_0000);
        chk("irq", 32'h0, 32'(irq_o));
        op_pulse(1);
        chk("ready", 32'h1, 32'(ready_busy_o));
        chk("irq", 32'h1, 32'(irq_o));
        rd_chk("irq status", `IRQ_STAT_ADDR, 32'h0000_0001);
        step(1);
        chk("irq", 32'h0, 32'(irq_o));
        // Window left to run out: late data must be refused
        wr(`IRQ_MASK_ADDR, 32'h0000_0008, 4'h1);
        wr(`SEC_CTRL_ADDR, `UNLOCK_KEY, 4'hF);
        step(20);
        chk("irq", 32'h1, 32'(irq_o));
        rd_chk("irq status", `IRQ_STAT_ADDR, 32'h0000_0008);
        wr(`SEC_CTRL_ADDR, 32'h0000_0001, 4'hF);
        rd_chk("security", `SEC_CTRL_ADDR, 32'h0000_0000);
        $display("test irq done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: both resets held 12 cycles, then the scenarios
    initial begin
        errors = 0;
        num_checks = 0;
        rst_i = 1'b1;
        por_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 32'h0000_0000;
        wb_dat_i = 32'h0000_0000;
        wb_sel_i = 4'h0;
        {op_start_i, op_done_i, op_fail_i, small_part_i} = 4'h0;
        boot_mode_i = MODE_SINGLE_CHIP;
        prot_init_i = 6'h21;
        {prot_write_i, prot_erase_i, prot_group_i} = 3'h0;
        prot_block_i = 3'h0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        t_reset();
        t_protect();
        t_fail();
        t_irq();
        wrap_up();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        $display("MISMATCH watchdog expected finish seen hang");
        wrap_up();
    end
endmodule // flash_protect_security_status_bench
